//--- src/lmcd_regs.svh
// register offsets, command codes and reset values of the decoder
// assumes word addressing on a 16-bit register port
`ifndef LMCD_REGS_SVH
`define LMCD_REGS_SVH

// ************************************
// coil and flag area
// ************************************
`define LMCD_ADDR_REMOTE_COIL 16'h0500
`define LMCD_ADDR_LOCKOUT_COIL 16'h0501
`define LMCD_ADDR_INPUT_FLAG 16'h0510

// ************************************
// command word, presets of two words each (high word first), mode and input read words
// ************************************
`define LMCD_ADDR_COMMAND 16'h0a00
`define LMCD_ADDR_PARAM_BASE 16'h0a01
`define LMCD_PARAM_WORDS 48
`define LMCD_ADDR_CURRENT_SET 16'h0a01
`define LMCD_ADDR_VOLTAGE_SET 16'h0a03
`define LMCD_ADDR_POWER_SET 16'h0a05
`define LMCD_ADDR_RESIST_SET 16'h0a07
`define LMCD_ADDR_CURRENT_RISE 16'h0a09
`define LMCD_ADDR_VOLTAGE_RISE 16'h0a0b
`define LMCD_ADDR_CUR_LOAD 16'h0a0d
`define LMCD_ADDR_CUR_UNLOAD 16'h0a0f
`define LMCD_ADDR_VOLT_LOAD 16'h0a11
`define LMCD_ADDR_VOLT_UNLOAD 16'h0a13
`define LMCD_ADDR_POW_LOAD 16'h0a15
`define LMCD_ADDR_POW_UNLOAD 16'h0a17
`define LMCD_ADDR_RES_LOAD 16'h0a19
`define LMCD_ADDR_RES_UNLOAD 16'h0a1b
`define LMCD_ADDR_CUR_SHIFT 16'h0a1d
`define LMCD_ADDR_RES_SHIFT 16'h0a1f
`define LMCD_ADDR_BATT_END 16'h0a2e
`define LMCD_ADDR_MODE_READ 16'h0b04
`define LMCD_ADDR_INPUT_READ 16'h0b05

// ************************************
// command codes, low byte only
// ************************************
`define LMCD_CODE_CONST_CURRENT 8'h01
`define LMCD_CODE_CONST_VOLTAGE 8'h02
`define LMCD_CODE_CONST_POWER 8'h03
`define LMCD_CODE_CONST_RESIST 8'h04
`define LMCD_CODE_CURRENT_SOFT 8'h14
`define LMCD_CODE_DYNAMIC 8'h19
`define LMCD_CODE_SHORT 8'h1a
`define LMCD_CODE_LIST 8'h1b
`define LMCD_CODE_CURRENT_LU 8'h1e
`define LMCD_CODE_VOLTAGE_LU 8'h1f
`define LMCD_CODE_POWER_LU 8'h20
`define LMCD_CODE_RESIST_LU 8'h21
`define LMCD_CODE_CUR_TO_VOLT 8'h22
`define LMCD_CODE_RES_TO_VOLT_A 8'h23
`define LMCD_CODE_RES_TO_VOLT_B 8'h24
`define LMCD_CODE_BATTERY 8'h26
`define LMCD_CODE_VOLTAGE_SOFT 8'h27
`define LMCD_CODE_APPLY_SYS 8'h29
`define LMCD_CODE_INPUT_ON 8'h2a
`define LMCD_CODE_INPUT_OFF 8'h2b

// ************************************
// reset values
// ************************************
`define LMCD_RST_CODE 8'h00
`define LMCD_RST_COIL 1'b0
`define LMCD_RST_INPUT 1'b0

`endif

//--- src/lmcd_pkg.sv
// types shared by the load mode command decoder
// assumes nothing of its surroundings
package lmcd_pkg;

    // ************************************
    // operating modes
    // ************************************
    typedef enum logic [4:0] {
        md_idle,
        md_const_current,
        md_const_voltage,
        md_const_power,
        md_const_resist,
        md_current_soft,
        md_voltage_soft,
        md_dynamic,
        md_short,
        md_list,
        md_current_lu,
        md_voltage_lu,
        md_power_lu,
        md_resist_lu,
        md_current_to_volt,
        md_resist_to_volt,
        md_battery
    } lmcd_mode_t;

    // ************************************
    // decoded command and values in force
    // ************************************
    typedef struct packed {
        logic valid;
        logic sel_mode;
        lmcd_mode_t mode;
        logic turn_on;
        logic turn_off;
        logic apply;
    } lmcd_dec_t;

    typedef struct packed {
        logic [31:0] setpoint;
        logic [31:0] load_level;
        logic [31:0] unload_level;
        logic [31:0] rise_time;
    } lmcd_active_t;

endpackage

//--- src/lmcd_top.sv
// load mode command decoder: coils, presets, command decode
// assumes a serial front end that turns frames into register
// strobes on mclk, one strobe at a time
// Function
// - codes 1-4 select basic regulation modes
// - 25 dynamic, 27 list, 41 apply system
// - remote coil enters and leaves remote
// - lockout coil forbids or permits panel
// - code 42 switches input on
// - code 43 switches input off
// - code 26 selects short circuit
// - code 1 regulates to stored current setpoint
// - code 2 uses stored voltage setpoint
// - code 3 uses stored power setpoint
// - code 4 uses stored resistance setpoint
// - code 20 current soft start, rise time
// - code 39 voltage soft start, rise time
// - code 30 current load/unload thresholds
// - code 31 voltage load/unload thresholds
// - code 32 power load/unload thresholds
// - code 33 resistance load/unload thresholds
// - code 34 current to voltage shift
// - resistance to voltage shift, 35 or 36
// - code 38 battery test, end voltage
// - presets optional, command write triggers
// - only low command byte is decoded
// - input state readable, 1 on 0 off
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "lmcd_regs.svh"

module lmcd_top #(
    parameter int ADDR_W = 16, // register address width
    parameter int DATA_W = 16, // register data width
    parameter int PARAM_WORDS = `LMCD_PARAM_WORDS // preset words
) (
    input wire logic mclk, // clock
    input wire logic nrst, // async reset, low
    input wire logic [ADDR_W-1:0] reg_addr, // word address
    input wire logic [DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [DATA_W-1:0] reg_rdata, // read data, next cycle
    output lmcd_pkg::lmcd_mode_t mode, // mode in force
    output logic [7:0] mode_code, // code of mode in force
    output logic input_on_flag, // load input on
    output lmcd_pkg::lmcd_active_t active, // values in force
    output logic sysparam_apply, // apply pulse
    output logic remote_control_coil, // remote control
    output logic local_lockout_coil // panel locked out
);

    // ************************************
    // elaboration checks
    // ************************************
    localparam int IDX_W = $clog2(PARAM_WORDS);
    if (ADDR_W != 16 || DATA_W != 16) begin : g_bad_width
        $error("port widths must be 16");
    end
    if (PARAM_WORDS < `LMCD_PARAM_WORDS) begin : g_bad_depth
        $error("preset area too small");
    end

    // ************************************
    // functions
    // ************************************
    logic [DATA_W-1:0] preset [PARAM_WORDS];
    function automatic logic in_params(input logic [15:0] a);
        logic [15:0] off;
        off = a - `LMCD_ADDR_PARAM_BASE;
        return (a >= `LMCD_ADDR_PARAM_BASE) &&
               (off < 16'(PARAM_WORDS));
    endfunction
    function automatic logic [IDX_W-1:0] idx(input logic [15:0] a);
        logic [15:0] off;
        off = a - `LMCD_ADDR_PARAM_BASE;
        return off[IDX_W-1:0];
    endfunction
    // two-word value, high word at the lower address
    function automatic logic [31:0] pair(input logic [15:0] a);
        logic [15:0] b;
        b = a + 16'h0001;
        return {preset[idx(a)], preset[idx(b)]};
    endfunction

    function automatic lmcd_pkg::lmcd_dec_t decode(
        input logic [7:0] code
    );
        lmcd_pkg::lmcd_dec_t d;
        d = '0;
        d.valid = 1'b1;
        d.sel_mode = 1'b1;
        case (code)
            `LMCD_CODE_CONST_CURRENT:
                d.mode = lmcd_pkg::md_const_current;
            `LMCD_CODE_CONST_VOLTAGE:
                d.mode = lmcd_pkg::md_const_voltage;
            `LMCD_CODE_CONST_POWER: d.mode = lmcd_pkg::md_const_power;
            `LMCD_CODE_CONST_RESIST:
                d.mode = lmcd_pkg::md_const_resist;
            `LMCD_CODE_CURRENT_SOFT:
                d.mode = lmcd_pkg::md_current_soft;
            `LMCD_CODE_VOLTAGE_SOFT:
                d.mode = lmcd_pkg::md_voltage_soft;
            `LMCD_CODE_DYNAMIC: d.mode = lmcd_pkg::md_dynamic;
            `LMCD_CODE_LIST: d.mode = lmcd_pkg::md_list;
            `LMCD_CODE_SHORT: d.mode = lmcd_pkg::md_short;
            `LMCD_CODE_CURRENT_LU: d.mode = lmcd_pkg::md_current_lu;
            `LMCD_CODE_VOLTAGE_LU: d.mode = lmcd_pkg::md_voltage_lu;
            `LMCD_CODE_POWER_LU: d.mode = lmcd_pkg::md_power_lu;
            `LMCD_CODE_RESIST_LU: d.mode = lmcd_pkg::md_resist_lu;
            `LMCD_CODE_CUR_TO_VOLT:
                d.mode = lmcd_pkg::md_current_to_volt;
            // both codes accepted until the host side is settled
            `LMCD_CODE_RES_TO_VOLT_A,
            `LMCD_CODE_RES_TO_VOLT_B:
                d.mode = lmcd_pkg::md_resist_to_volt;
            `LMCD_CODE_BATTERY: d.mode = lmcd_pkg::md_battery;
            `LMCD_CODE_APPLY_SYS: begin
                d.sel_mode = 1'b0;
                d.apply = 1'b1;
            end
            `LMCD_CODE_INPUT_ON: begin
                d.sel_mode = 1'b0;
                d.turn_on = 1'b1;
            end
            `LMCD_CODE_INPUT_OFF: begin
                d.sel_mode = 1'b0;
                d.turn_off = 1'b1;
            end
            default: d = '0;
        endcase
        return d;
    endfunction

    // ************************************
    // command decode
    // ************************************
    logic cmd_wr;
    logic [7:0] cmd_byte;
    lmcd_pkg::lmcd_dec_t dec;
    lmcd_pkg::lmcd_active_t next_active;
    logic [7:0] cmd_last;
    assign cmd_wr = reg_wr && (reg_addr == `LMCD_ADDR_COMMAND);
    assign cmd_byte = reg_wdata[7:0];
    assign dec = decode(cmd_byte);
    // only the command write acts; presets just sit in storage
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mode <= lmcd_pkg::md_idle;
            mode_code <= `LMCD_RST_CODE;
        end else if (cmd_wr && dec.valid && dec.sel_mode) begin
            mode <= dec.mode;
            mode_code <= cmd_byte;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmd_last <= `LMCD_RST_CODE;
        end else if (cmd_wr && dec.valid) begin
            cmd_last <= cmd_byte;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            input_on_flag <= `LMCD_RST_INPUT;
        end else if (cmd_wr && dec.turn_on) begin
            input_on_flag <= 1'b1;
        end else if (cmd_wr && dec.turn_off) begin
            input_on_flag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sysparam_apply <= 1'b0;
        end else begin
            sysparam_apply <= cmd_wr && dec.apply;
        end
    end

    // ************************************
    // values snapshot
    // ************************************
    // bus strobes never overlap, so every preset is stored
    // before the command that uses it is seen
    always_comb begin
        next_active = active;
        case (dec.mode)
            lmcd_pkg::md_const_current:
                next_active.setpoint = pair(`LMCD_ADDR_CURRENT_SET);
            lmcd_pkg::md_const_voltage:
                next_active.setpoint = pair(`LMCD_ADDR_VOLTAGE_SET);
            lmcd_pkg::md_const_power:
                next_active.setpoint = pair(`LMCD_ADDR_POWER_SET);
            lmcd_pkg::md_const_resist:
                next_active.setpoint = pair(`LMCD_ADDR_RESIST_SET);
            lmcd_pkg::md_current_soft: begin
                next_active.setpoint = pair(`LMCD_ADDR_CURRENT_SET);
                next_active.rise_time = pair(`LMCD_ADDR_CURRENT_RISE);
            end
            lmcd_pkg::md_voltage_soft: begin
                next_active.setpoint = pair(`LMCD_ADDR_VOLTAGE_SET);
                next_active.rise_time = pair(`LMCD_ADDR_VOLTAGE_RISE);
            end
            lmcd_pkg::md_current_lu: begin
                next_active.setpoint = pair(`LMCD_ADDR_CURRENT_SET);
                next_active.load_level = pair(`LMCD_ADDR_CUR_LOAD);
                next_active.unload_level = pair(`LMCD_ADDR_CUR_UNLOAD);
            end
            lmcd_pkg::md_voltage_lu: begin
                next_active.setpoint = pair(`LMCD_ADDR_VOLTAGE_SET);
                next_active.load_level = pair(`LMCD_ADDR_VOLT_LOAD);
                next_active.unload_level = pair(`LMCD_ADDR_VOLT_UNLOAD);
            end
            lmcd_pkg::md_power_lu: begin
                next_active.setpoint = pair(`LMCD_ADDR_POWER_SET);
                next_active.load_level = pair(`LMCD_ADDR_POW_LOAD);
                next_active.unload_level = pair(`LMCD_ADDR_POW_UNLOAD);
            end
            lmcd_pkg::md_resist_lu: begin
                next_active.setpoint = pair(`LMCD_ADDR_RESIST_SET);
                next_active.load_level = pair(`LMCD_ADDR_RES_LOAD);
                next_active.unload_level = pair(`LMCD_ADDR_RES_UNLOAD);
            end
            lmcd_pkg::md_current_to_volt: begin
                next_active.setpoint = pair(`LMCD_ADDR_CURRENT_SET);
                next_active.load_level = pair(`LMCD_ADDR_CUR_SHIFT);
            end
            lmcd_pkg::md_resist_to_volt: begin
                next_active.setpoint = pair(`LMCD_ADDR_RESIST_SET);
                next_active.load_level = pair(`LMCD_ADDR_RES_SHIFT);
            end
            lmcd_pkg::md_battery: begin
                next_active.setpoint = pair(`LMCD_ADDR_CURRENT_SET);
                next_active.load_level = pair(`LMCD_ADDR_BATT_END);
            end
            default: next_active = active;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            active <= '0;
        end else if (cmd_wr && dec.valid && dec.sel_mode) begin
            active <= next_active;
        end
    end

    // ************************************
    // coils and preset storage
    // ************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            remote_control_coil <= `LMCD_RST_COIL;
        end else if (reg_wr && reg_addr == `LMCD_ADDR_REMOTE_COIL) begin
            remote_control_coil <= |reg_wdata;
        end
    end

    // the lockout coil is handed to the panel logic as is
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            local_lockout_coil <= `LMCD_RST_COIL;
        end else if (reg_wr && reg_addr == `LMCD_ADDR_LOCKOUT_COIL) begin
            local_lockout_coil <= |reg_wdata;
        end
    end

    // untouched presets keep their old value
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < PARAM_WORDS; i++) begin
                preset[i] <= '0;
            end
        end else if (reg_wr && in_params(reg_addr)) begin
            preset[idx(reg_addr)] <= reg_wdata;
        end
    end

    // ************************************
    // read port
    // ************************************
    logic [DATA_W-1:0] next_rdata;
    always_comb begin
        next_rdata = '0;
        if (reg_rd) begin
            if (in_params(reg_addr)) begin
                next_rdata = preset[idx(reg_addr)];
            end else begin
                case (reg_addr)
                    `LMCD_ADDR_REMOTE_COIL:
                        next_rdata[0] = remote_control_coil;
                    `LMCD_ADDR_LOCKOUT_COIL:
                        next_rdata[0] = local_lockout_coil;
                    `LMCD_ADDR_INPUT_FLAG,
                    `LMCD_ADDR_INPUT_READ:
                        next_rdata[0] = input_on_flag;
                    `LMCD_ADDR_COMMAND:
                        next_rdata[7:0] = cmd_last;
                    `LMCD_ADDR_MODE_READ:
                        next_rdata[7:0] = mode_code;
                    default: next_rdata = '0;
                endcase
            end
        end
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ************************************
    // assertions
    // ************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    logic [31:0] cur_pair;
    logic [31:0] res_pair;
    logic [31:0] rise_pair;
    assign cur_pair = pair(`LMCD_ADDR_CURRENT_SET);
    assign res_pair = pair(`LMCD_ADDR_RESIST_SET);
    assign rise_pair = pair(`LMCD_ADDR_CURRENT_RISE);

    basic_select_a: assert property (
        cmd_wr && cmd_byte >= 8'h01 && cmd_byte <= 8'h04
        |=> mode_code == $past(cmd_byte) && mode != lmcd_pkg::md_idle)
        else $error("basic mode not selected");
    ext_codes_a: assert property (
        cmd_wr && cmd_byte == `LMCD_CODE_APPLY_SYS
        |=> sysparam_apply ##1
            sysparam_apply == ($past(cmd_wr) && $past(dec.apply)))
        else $error("apply pulse wrong");
    remote_coil_a: assert property (
        reg_wr && reg_addr == `LMCD_ADDR_REMOTE_COIL
        |=> remote_control_coil == (|$past(reg_wdata)))
        else $error("remote coil not tracked");
    lockout_coil_a: assert property (
        reg_wr && reg_addr == `LMCD_ADDR_LOCKOUT_COIL
        |=> local_lockout_coil == (|$past(reg_wdata)))
        else $error("lockout coil not tracked");
    input_on_a: assert property (
        cmd_wr && cmd_byte == `LMCD_CODE_INPUT_ON
        |=> input_on_flag && $stable(mode))
        else $error("input not switched on");
    input_off_a: assert property (
        cmd_wr && cmd_byte == `LMCD_CODE_INPUT_OFF
        |=> !input_on_flag)
        else $error("input not switched off");
    short_mode_a: assert property (
        cmd_wr && cmd_byte == `LMCD_CODE_SHORT
        |=> mode == lmcd_pkg::md_short)
        else $error("short mode not selected");
    current_value_a: assert property (
        cmd_wr && cmd_byte == `LMCD_CODE_CONST_CURRENT
        |=> active.setpoint == $past(cur_pair))
        else $error("current setpoint not taken");
    soft_rise_a: assert property (
        cmd_wr && cmd_byte == `LMCD_CODE_CURRENT_SOFT
        |=> active.rise_time == $past(rise_pair))
        else $error("rise time not taken");
    resist_shift_a: assert property (
        cmd_wr && (cmd_byte == `LMCD_CODE_RES_TO_VOLT_A ||
                   cmd_byte == `LMCD_CODE_RES_TO_VOLT_B)
        |=> mode == lmcd_pkg::md_resist_to_volt &&
            active.setpoint == $past(res_pair))
        else $error("resistance shift wrong");
    preset_only_a: assert property (
        reg_wr && !cmd_wr |=> $stable(mode) && $stable(active))
        else $error("preset changed the mode");
    high_byte_a: assert property (
        cmd_wr && cmd_byte == `LMCD_CODE_INPUT_ON && reg_wdata[15:8] != 8'h00
        |=> input_on_flag)
        else $error("upper byte not ignored");
    flag_read_a: assert property (
        reg_rd && reg_addr == `LMCD_ADDR_INPUT_FLAG
        |=> reg_rdata == {15'h0000, $past(input_on_flag)} ##1
            (reg_rdata == '0 || $past(reg_rd)))
        else $error("input flag read wrong");
    unknown_code_a: assert property (
        cmd_wr && !dec.valid
        |=> $stable(mode) && $stable(input_on_flag) && $stable(active))
        else $error("unknown code acted on");

endmodule

`default_nettype wire

//--- dv/lmcd_host.sv
// host computer model: drives the register port of the decoder
// assumes one strobe at a time, changed just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module lmcd_host (
    input wire logic mclk, // clock
    output logic [15:0] reg_addr, // word address
    output logic [15:0] reg_wdata, // write data
    output logic reg_wr, // write strobe
    output logic reg_rd, // read strobe
    input wire logic [15:0] reg_rdata // read data
);
    initial begin
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // ************************************
    // bus cycles
    // ************************************
    // coils forced, presets optional, command word last
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        // released lines show no stale value
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge mclk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

//--- dv/test_load_mode_command_decoder.sv
// self-checking bench of the load mode command decoder
// assumes the host model is the only master of the register port
`timescale 1ns/1ps
`default_nettype none
`include "lmcd_regs.svh"
module test_load_mode_command_decoder;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic reg_wr, reg_rd, input_on_flag, sysparam_apply;
    logic remote_control_coil, local_lockout_coil, exp_on;
    lmcd_pkg::lmcd_mode_t mode;
    lmcd_pkg::lmcd_active_t active, exp_act;
    logic [7:0] mode_code, exp_c, last_code, o;
    logic [4:0] exp_m;
    logic [15:0] lf = 16'h005c;
    logic [15:0] mem [0:63];
    logic [7:0] codes [0:21] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h14,
        8'h27, 8'h19, 8'h1a, 8'h1b, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22,
        8'h23, 8'h24, 8'h26, 8'h29, 8'h2a, 8'h2b, 8'h05, 8'h2c};
    int err_total = 0;
    int checked = 0;
    always #4 mclk = ~mclk;
    lmcd_top lmcd_top_inst (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mode(mode), .mode_code(mode_code),
        .input_on_flag(input_on_flag), .active(active),
        .sysparam_apply(sysparam_apply),
        .remote_control_coil(remote_control_coil),
        .local_lockout_coil(local_lockout_coil));
    lmcd_host lmcd_host_inst (.mclk(mclk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    // ************************************
    // expectation helpers
    // ************************************
    function logic [15:0] nxt(input logic [15:0] s);
        nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // mode, then setpoint, load, unload, rise offsets; 0 = untouched
    function logic [36:0] tab(input logic [7:0] c);
        case (c)
            8'h01: tab = {5'h01, 32'h01000000};
            8'h02: tab = {5'h02, 32'h03000000};
            8'h03: tab = {5'h03, 32'h05000000};
            8'h04: tab = {5'h04, 32'h07000000};
            8'h14: tab = {5'h05, 32'h01000009};
            8'h27: tab = {5'h06, 32'h0300000b};
            8'h19: tab = {5'h07, 32'h00000000};
            8'h1a: tab = {5'h08, 32'h00000000};
            8'h1b: tab = {5'h09, 32'h00000000};
            8'h1e: tab = {5'h0a, 32'h010d0f00};
            8'h1f: tab = {5'h0b, 32'h03111300};
            8'h20: tab = {5'h0c, 32'h05151700};
            8'h21: tab = {5'h0d, 32'h07191b00};
            8'h22: tab = {5'h0e, 32'h011d0000};
            8'h23, 8'h24: tab = {5'h0f, 32'h071f0000};
            8'h26: tab = {5'h10, 32'h012e0000};
            default: tab = 37'h0;
        endcase
    endfunction
    function logic [31:0] pr(input logic [7:0] a);
        pr = {mem[a], mem[a + 8'h01]};
    endfunction
    task chk(input logic [127:0] got, input logic [127:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task results;
        $display("mismatches %0d comparisons %0d", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task preset;
        o = 8'(lf[5:0] % 48) + 8'h01;
        lf = nxt(lf);
        mem[o] = lf;
        lmcd_host_inst.wr({8'h0a, o}, lf);
        lf = nxt(lf);
    endtask
    task cmd(input logic [7:0] c);
        logic [36:0] e;
        e = tab(c);
        // random upper byte must be ignored
        lmcd_host_inst.wr(`LMCD_ADDR_COMMAND, {lf[15:8], c});
        lf = nxt(lf);
        if (e[36:32] != 5'h00) begin
            exp_m = e[36:32];
            exp_c = c;
            last_code = c;
            if (e[31:24] != 8'h00) exp_act.setpoint = pr(e[31:24]);
            if (e[23:16] != 8'h00) exp_act.load_level = pr(e[23:16]);
            if (e[15:8] != 8'h00) exp_act.unload_level = pr(e[15:8]);
            if (e[7:0] != 8'h00) exp_act.rise_time = pr(e[7:0]);
        end
        if (c == 8'h29 || c == 8'h2a || c == 8'h2b) last_code = c;
        if (c == 8'h2a) exp_on = 1'b1;
        if (c == 8'h2b) exp_on = 1'b0;
        @(negedge mclk);
        chk(mode, exp_m);
        chk(mode_code, exp_c);
        chk(active, exp_act);
        chk(active, exp_act);
        chk(input_on_flag, exp_on);
        chk(sysparam_apply, c == 8'h29);
    endtask
    // ************************************
    // main sequence
    // ************************************
    initial begin
        exp_act = '0;
        exp_m = 5'h00;
        exp_c = 8'h00;
        last_code = 8'h00;
        exp_on = 1'b0;
        for (int i = 0; i < 64; i++) mem[i] = 16'h0000;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        @(negedge mclk);
        chk({mode, mode_code, input_on_flag, remote_control_coil,
            local_lockout_coil}, '0);
        chk(active, '0);
        for (int i = 0; i < 4; i++) begin
            lmcd_host_inst.wr(`LMCD_ADDR_REMOTE_COIL, {{8{i[0]}}, 8'h00});
            lmcd_host_inst.wr(`LMCD_ADDR_LOCKOUT_COIL, {15'h0, i[1]});
            @(negedge mclk);
            chk(remote_control_coil, i[0]);
            chk(local_lockout_coil, i[1]);
        end
        repeat (48) preset();
        lmcd_host_inst.rd({8'h0a, o}, rv);
        chk(rv, mem[o]);
        for (int k = 0; k < 44; k++) begin
            if (k >= 22) preset();
            cmd(codes[k % 22]);
            cmd(lf[7:0]);
            lf = nxt(lf);
        end
        cmd(8'h2a);
        lmcd_host_inst.rd(`LMCD_ADDR_COMMAND, rv);
        chk(rv, {8'h00, last_code});
        lmcd_host_inst.rd(`LMCD_ADDR_MODE_READ, rv);
        chk(rv, {8'h00, exp_c});
        lmcd_host_inst.rd(`LMCD_ADDR_INPUT_FLAG, rv);
        chk(rv, {15'h0, exp_on});
        lmcd_host_inst.rd(`LMCD_ADDR_INPUT_READ, rv);
        chk(rv, {15'h0, exp_on});
        lmcd_host_inst.rd(16'h0700, rv);
        chk(rv, 16'h0000);
        results();
    end
    initial begin
        #400000;
        err_total++;
        results();
    end
endmodule
`default_nettype wire
